// ### common/ssnc_pkg.sv
package ssnc_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [1:0] SSNC_OFS_GCR    = 2'h0;
	localparam logic [1:0] SSNC_OFS_MUX    = 2'h1;
	localparam logic [1:0] SSNC_OFS_STATUS = 2'h2;

	localparam logic [7:0] SSNC_GCR_RESET  = 8'h03;
	localparam logic [5:0] SSNC_MUX_RESET  = 6'h2d;
	// Mux code that selects pass-through and acts as software reset
	localparam logic [5:0] SSNC_MUX_PASSTHRU = 6'h2d;

	// Field positions of the general control register
	localparam int SSNC_GCR_LINE_POL  = 0;
	localparam int SSNC_GCR_FRAME_POL = 1;
	localparam int SSNC_GCR_SPLIT     = 2;
	localparam int SSNC_GCR_NIBBLE    = 3;
	localparam int SSNC_GCR_PEDESTAL  = 4;
	localparam int SSNC_GCR_GREEN_SYN = 5;
	localparam int SSNC_GCR_BIG_END   = 6;
	localparam int SSNC_GCR_INDICATOR = 7;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int SSNC_CLK_PERIOD_NS    = 100;
	localparam int SSNC_PULSE_START_NS   = 20;
	localparam int SSNC_PULSE_HIGH_NS    = 15;
	// Longest start time rounds down, never below one cycle
	localparam int SSNC_PULSE_START_CYC  =
		(SSNC_PULSE_START_NS / SSNC_CLK_PERIOD_NS) < 1 ? 1 :
		(SSNC_PULSE_START_NS / SSNC_CLK_PERIOD_NS);
	// Least high time rounds up
	localparam int SSNC_PULSE_HIGH_CYC   =
		(SSNC_PULSE_HIGH_NS + SSNC_CLK_PERIOD_NS - 1) / SSNC_CLK_PERIOD_NS;

	localparam int SSNC_PIX_W = 32;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic indicator;
		logic big_endian;
		logic green_sync;
		logic pedestal;
		logic nibble_en;
		logic split_en;
		logic frame_pol;
		logic line_pol;
	} ssnc_gcr_s;

	// Active-low control inputs, as sampled
	typedef struct packed {
		logic retrace_n;
		logic frame_n;
		logic line_n;
	} ssnc_ctl_s;

	localparam ssnc_ctl_s SSNC_CTL_IDLE = 3'h7;

endpackage

// ### core/ssnc_sync.sv
`timescale 1ns/1ps
module ssnc_sync
	import ssnc_pkg::*;
#(
	parameter int          W   = 1,
	parameter logic [W-1:0] RST = '0
)(
	input  wire logic         clk,
	input  wire logic         reset,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] s1_q, s2_q, s3_q, out_q;
	logic [W-1:0] out_d;

	// ----------------------------------------------------------------
	// Accept a change only once the second and third stages agree
	// ----------------------------------------------------------------
	generate
		for (genvar i = 0; i < W; i++)
		begin : g_bit
			assign out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
		end
	endgenerate

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			s1_q  <= RST;
			s2_q  <= RST;
			s3_q  <= RST;
			out_q <= RST;
		end
		else
		begin
			s1_q  <= async_in;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			out_q <= out_d;
		end
	end

	assign sync_out = out_q;

endmodule // ssnc_sync

// ### core/ssnc_core.sv
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module ssnc_core
	import ssnc_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  reset,
	input  wire logic [1:0]            reg_addr,
	input  wire logic [7:0]            reg_wdata,
	input  wire logic                  reg_write,
	input  wire logic                  reg_read,
	output logic      [7:0]            reg_rdata,
	input  wire logic                  video_ctrl_clock,
	input  wire logic                  pass_clock_in,
	input  wire logic                  line_sync_in_n,
	input  wire logic                  frame_sync_in_n,
	input  wire logic                  retrace_gate_in_n,
	input  wire logic                  split_or_nibble_flag,
	input  wire logic [SSNC_PIX_W-1:0] pixel_in,
	input  wire logic                  shift_clock_base,
	output logic                       shift_clock,
	output logic [SSNC_PIX_W-1:0]      pixel_out,
	output logic                       line_sync_out,
	output logic                       frame_sync_out,
	output logic                       retrace_gate_out_n,
	output logic                       green_current_output,
	output logic                       pedestal_out,
	output logic                       big_endian_out,
	output logic                       passthrough_indicator_out
);

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	localparam int SW = 6 + SSNC_PIX_W;
	logic [SW-1:0] sync_raw, sync_val;
	ssnc_ctl_s     ctl_s;
	logic          vctl_s, pclk_s, flag_s;
	logic [SSNC_PIX_W-1:0] pix_s;

	assign sync_raw = {video_ctrl_clock, pass_clock_in, split_or_nibble_flag,
		retrace_gate_in_n, frame_sync_in_n, line_sync_in_n, pixel_in};

	ssnc_sync #(
		.W   (SW),
		.RST ({6'h07, {SSNC_PIX_W{1'b0}}})
	) u_sync (
		.clk      (clk),
		.reset    (reset),
		.async_in (sync_raw),
		.sync_out (sync_val)
	);

	assign {vctl_s, pclk_s, flag_s} = sync_val[SW-1 -: 3];
	assign ctl_s = sync_val[SSNC_PIX_W +: 3];
	assign pix_s = sync_val[SSNC_PIX_W-1:0];

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	ssnc_gcr_s gcr_q, gcr_d;
	logic [5:0] mux_q, mux_d;
	logic [7:0] rdata_q, rdata_d;
	logic vctl_prev_q, vctl_prev_d, pclk_prev_q, pclk_prev_d;
	logic flag_prev_q, flag_prev_d;
	ssnc_ctl_s lat_q, lat_d, mid_q, mid_d;
	logic [SSNC_PIX_W-1:0] plat_q, plat_d, pmid_q, pmid_d, pout_q, pout_d;
	logic line_q, line_d, frame_q, frame_d, retr_q, retr_d;
	logic green_q, green_d, ped_q, ped_d, bige_q, bige_d;
	logic ind_q, ind_d, extra_q, extra_d, sclk_q, sclk_d;

	logic passthru, sample, soft_rst, nibble_on, split_on;
	logic [SSNC_PIX_W-1:0] pix_ord, pix_nib;

	assign passthru  = (mux_q == SSNC_MUX_PASSTHRU);
	assign nibble_on = gcr_q.nibble_en && !gcr_q.split_en;
	assign split_on  = gcr_q.split_en && !gcr_q.nibble_en;
	// Latch strobe per mode
	assign sample    = passthru ? (pclk_s && !pclk_prev_q)
		: (vctl_prev_q && !vctl_s);
	assign soft_rst  = reg_write && (reg_addr == SSNC_OFS_MUX)
		&& (reg_wdata[5:0] == SSNC_MUX_PASSTHRU);

	// ----------------------------------------------------------------
	// Byte order and nibble selection
	// ----------------------------------------------------------------
	generate
		for (genvar i = 0; i < SSNC_PIX_W; i++)
		begin : g_order
			// Big-endian buses arrive bit-reversed
			assign pix_ord[i] = gcr_q.big_endian ?
				pix_s[SSNC_PIX_W-1-i] : pix_s[i];
		end
		for (genvar b = 0; b < SSNC_PIX_W/8; b++)
		begin : g_nib
			// Upper or lower nibble, top four zeroed
			assign pix_nib[8*b +: 8] = {4'h0, flag_s ?
				plat_q[8*b+4 +: 4] : plat_q[8*b +: 4]};
		end
	endgenerate

	// ----------------------------------------------------------------
	// Registers and pipeline
	// ----------------------------------------------------------------
	always_comb
	begin
		gcr_d       = gcr_q;
		mux_d       = mux_q;
		rdata_d     = 8'h00;
		vctl_prev_d = vctl_s;
		pclk_prev_d = pclk_s;
		flag_prev_d = flag_s;
		lat_d  = lat_q;
		mid_d  = mid_q;
		plat_d = plat_q;
		pmid_d = pmid_q;
		pout_d = pout_q;
		if (reg_write && reg_addr == SSNC_OFS_GCR)
			gcr_d = reg_wdata;
		if (reg_write && reg_addr == SSNC_OFS_MUX)
			mux_d = reg_wdata[5:0];
		if (soft_rst)
			gcr_d = SSNC_GCR_RESET;
		if (reg_read)
		begin
			unique case (reg_addr)
				SSNC_OFS_GCR:    rdata_d = gcr_q;
				SSNC_OFS_MUX:    rdata_d = {2'h0, mux_q};
				SSNC_OFS_STATUS: rdata_d = {3'h0, passthru, flag_s,
					mid_q.retrace_n, mid_q.frame_n, mid_q.line_n};
				default:         rdata_d = 8'h00;
			endcase
		end
		// Control and data share the same stages
		if (sample)
		begin
			lat_d  = ctl_s;
			plat_d = pix_ord;
			mid_d  = lat_q;
			// Nibble select ignores the mux mode
			pmid_d = nibble_on ? pix_nib : plat_q;
			pout_d = pmid_q;
		end
		if (soft_rst)
		begin
			lat_d  = SSNC_CTL_IDLE;
			mid_d  = SSNC_CTL_IDLE;
			plat_d = '0;
			pmid_d = '0;
			pout_d = '0;
		end
	end

	// ----------------------------------------------------------------
	// Output stage
	// ----------------------------------------------------------------
	always_comb
	begin
		line_d  = line_q;
		frame_d = frame_q;
		retr_d  = retr_q;
		green_d = green_q;
		if (sample)
		begin
			// Pass-through forwards as is else true/complement
			line_d  = passthru ? mid_q.line_n
				: (gcr_q.line_pol ? !mid_q.line_n : mid_q.line_n);
			frame_d = passthru ? mid_q.frame_n
				: (gcr_q.frame_pol ? !mid_q.frame_n : mid_q.frame_n);
			retr_d  = mid_q.retrace_n;
			// Any active sync kills the current, blank ignored
			green_d = gcr_q.green_sync && mid_q.line_n && mid_q.frame_n;
		end
		ped_d  = gcr_q.pedestal;
		bige_d = gcr_q.big_endian;
		ind_d  = passthru ? 1'b0 : gcr_q.indicator;
		// One pulse per synchronised rising edge
		extra_d = split_on && flag_s && !flag_prev_q;
		// Low flag leaves the base clock untouched
		sclk_d  = shift_clock_base || extra_d;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			gcr_q       <= SSNC_GCR_RESET;
			mux_q       <= SSNC_MUX_RESET;
			rdata_q     <= 8'h00;
			vctl_prev_q <= 1'b0;
			pclk_prev_q <= 1'b0;
			flag_prev_q <= 1'b0;
			lat_q       <= SSNC_CTL_IDLE;
			mid_q       <= SSNC_CTL_IDLE;
			plat_q      <= '0;
			pmid_q      <= '0;
			pout_q      <= '0;
			line_q      <= 1'b0;
			frame_q     <= 1'b0;
			retr_q      <= 1'b1;
			green_q     <= 1'b0;
			ped_q       <= 1'b0;
			bige_q      <= 1'b0;
			ind_q       <= 1'b0;
			extra_q     <= 1'b0;
			sclk_q      <= 1'b0;
		end
		else
		begin
			gcr_q       <= gcr_d;
			mux_q       <= mux_d;
			rdata_q     <= rdata_d;
			vctl_prev_q <= vctl_prev_d;
			pclk_prev_q <= pclk_prev_d;
			flag_prev_q <= flag_prev_d;
			lat_q       <= lat_d;
			mid_q       <= mid_d;
			plat_q      <= plat_d;
			pmid_q      <= pmid_d;
			pout_q      <= pout_d;
			line_q      <= line_d;
			frame_q     <= frame_d;
			retr_q      <= retr_d;
			green_q     <= green_d;
			ped_q       <= ped_d;
			bige_q      <= bige_d;
			ind_q       <= ind_d;
			extra_q     <= extra_d;
			sclk_q      <= sclk_d;
		end
	end

	assign reg_rdata                 = rdata_q;
	assign shift_clock               = sclk_q;
	assign pixel_out                 = pout_q;
	assign line_sync_out             = line_q;
	assign frame_sync_out            = frame_q;
	assign retrace_gate_out_n        = retr_q;
	assign green_current_output      = green_q;
	assign pedestal_out              = ped_q;
	assign big_endian_out            = bige_q;
	assign passthrough_indicator_out = ind_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	a_line_polarity: assert property (sample && !passthru ##1 1 |=>
		line_sync_out == ($past(gcr_q.line_pol, 2)
		^ $past(mid_q.line_n, 2)))
		else $error("line sync polarity wrong");
	a_pass_forward: assert property (sample && passthru |=>
		frame_sync_out == $past(mid_q.frame_n))
		else $error("pass-through frame sync altered");
	a_pipe_delay: assert property (sample && !soft_rst |=>
		mid_q == $past(lat_q) && pout_q == $past(pmid_q)
		&& retrace_gate_out_n == $past(mid_q.retrace_n))
		else $error("retrace pipeline misaligned");
	a_green_kill: assert property ($rose(green_current_output) |->
		$past(mid_q.line_n) && $past(mid_q.frame_n)
		&& $past(gcr_q.green_sync))
		else $error("green sync on during active sync");
	a_extra_pulse: assert property (split_on && $rose(flag_s) ##0
		!$past(extra_q) |=> shift_clock ##1 !extra_q)
		else $error("extra shift pulse missing");
	a_flag_ignored: assert property (!gcr_q.split_en && !gcr_q.nibble_en
		|=> !extra_q)
		else $error("flag acted on while disabled");
	a_nibble_zero: assert property (sample && nibble_on |=>
		pmid_q[7:4] == 4'h0 && pmid_q[31:28] == 4'h0)
		else $error("nibble upper bits not zero");
	a_indicator: assert property (passthru |=>
		!passthrough_indicator_out || !$past(passthru, 1))
		else $error("indicator high in pass-through");
	a_soft_reset: assert property (soft_rst |=>
		gcr_q == SSNC_GCR_RESET ##1 !passthrough_indicator_out)
		else $error("software reset incomplete");
	a_pedestal: assert property (##1 pedestal_out == $past(gcr_q.pedestal))
		else $error("pedestal not following control");

	c_split_pulse:  cover property (split_on && extra_q);
	c_nibble_upper: cover property (sample && nibble_on && flag_s);
	c_soft_reset:   cover property (soft_rst ##1 passthru);
	c_normal_sync:  cover property (sample && !passthru && !mid_q.line_n);

endmodule // ssnc_core

// ### test/ssnc_far_model.sv
`timescale 1ns/1ps
module ssnc_far_model
	import ssnc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        blank_req,
	input  wire logic        line_req,
	input  wire logic        frame_req,
	input  wire logic        flag_req,
	input  wire logic [31:0] pix_req,
	output logic             video_ctrl_clock,
	output logic             pass_clock_in,
	output logic             line_sync_in_n,
	output logic             frame_sync_in_n,
	output logic             retrace_gate_in_n,
	output logic             split_or_nibble_flag,
	output logic [31:0]      pixel_in,
	output logic             shift_clock_base
);
	// ----------------------------------------------------------------
	// Timing source
	// ----------------------------------------------------------------
	logic [2:0] cnt_q;

	// Pins change at count 0, at least three cycles clear of either latch edge
	assign video_ctrl_clock = ~cnt_q[2];
	assign pass_clock_in    = cnt_q[2];
	// Memory shift clock stops during blanking, as real frame buffers do
	assign shift_clock_base = cnt_q[1] & retrace_gate_in_n;

	always_ff @(posedge clk)
	begin
		cnt_q <= reset ? 3'h0 : cnt_q + 3'h1;
		if (reset)
		begin
			retrace_gate_in_n    <= 1'b1;
			line_sync_in_n       <= 1'b1;
			frame_sync_in_n      <= 1'b1;
			split_or_nibble_flag <= 1'b0;
			pixel_in             <= 32'h0;
		end
		else if (cnt_q == 3'h0)
		begin
			retrace_gate_in_n <= ~blank_req;
			line_sync_in_n    <= ~(line_req & blank_req);
			frame_sync_in_n   <= ~(frame_req & blank_req);
			if (blank_req)
				split_or_nibble_flag <= flag_req;
			pixel_in <= pix_req;
		end
	end
endmodule // ssnc_far_model

// ### test/tb_top.sv
`timescale 1ns/1ps
module tb_top
	import ssnc_pkg::*;
;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic [1:0]  reg_addr = 2'h0;
	logic [7:0]  reg_wdata = 8'h0;
	logic        reg_write = 1'b0;
	logic        reg_read = 1'b0;
	logic [7:0]  reg_rdata;
	logic        blank_req = 1'b0;
	logic        line_req = 1'b0;
	logic        frame_req = 1'b0;
	logic        flag_req = 1'b0;
	logic [31:0] pix_req = 32'h0;
	logic        vctl, pclk, line_n, frame_n, retr_n, flag, sbase;
	logic [31:0] pix_in, pixel_out;
	logic        shift_clock, line_sync_out, frame_sync_out, retr_out_n;
	logic        green, pedestal, big_end, indicator;
	logic [7:0]  d;
	int          err_count = 0;
	int          samples_checked = 0;

	always #50 clk = ~clk;

	ssnc_far_model i_ssnc_far_model (.clk(clk), .reset(reset),
		.blank_req(blank_req), .line_req(line_req), .frame_req(frame_req),
		.flag_req(flag_req), .pix_req(pix_req), .video_ctrl_clock(vctl),
		.pass_clock_in(pclk), .line_sync_in_n(line_n),
		.frame_sync_in_n(frame_n), .retrace_gate_in_n(retr_n),
		.split_or_nibble_flag(flag), .pixel_in(pix_in),
		.shift_clock_base(sbase));

	ssnc_core i_ssnc_core (.clk(clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .video_ctrl_clock(vctl), .pass_clock_in(pclk),
		.line_sync_in_n(line_n), .frame_sync_in_n(frame_n),
		.retrace_gate_in_n(retr_n), .split_or_nibble_flag(flag),
		.pixel_in(pix_in), .shift_clock_base(sbase),
		.shift_clock(shift_clock), .pixel_out(pixel_out),
		.line_sync_out(line_sync_out), .frame_sync_out(frame_sync_out),
		.retrace_gate_out_n(retr_out_n), .green_current_output(green),
		.pedestal_out(pedestal), .big_endian_out(big_end),
		.passthrough_indicator_out(indicator));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task stop_test;
		if (err_count == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	task wr(input logic [1:0] a, input logic [7:0] v);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask

	task rd(input logic [1:0] a, output logic [7:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		@(negedge clk);
		v = reg_rdata;
	endtask

	// Long enough for sync stages plus three latch strobes of 8 cycles
	task video(input logic b, l, f, fl, input logic [31:0] p);
		@(posedge clk);
		blank_req <= b;
		line_req  <= l;
		frame_req <= f;
		flag_req  <= fl;
		pix_req   <= p;
		repeat (64) @(posedge clk);
		@(negedge clk);
	endtask

	// Unknown levels poison the sum instead of counting as low
	task count_high(output logic [31:0] n);
		n = 32'h0;
		repeat (64)
		begin
			@(negedge clk);
			n = n + 32'(shift_clock);
		end
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task t_reset;
		rd(2'h0, d);
		chk("gcr reset", 32'h03, d);
		chk("indicator", 32'h0, indicator);
		chk("pedestal", 32'h0, pedestal);
		chk("green", 32'h0, green);
		chk("big endian", 32'h0, big_end);
		rd(2'h3, d);
		chk("unmapped read", 32'h0, d);
	endtask

	task t_control;
		wr(2'h0, 8'h80);
		chk("indicator pass", 32'h0, indicator);
		wr(2'h1, 8'h00);
		chk("indicator set", 32'h1, indicator);
		wr(2'h0, 8'h70);
		chk("indicator clr", 32'h0, indicator);
		chk("pedestal on", 32'h1, pedestal);
		chk("big on", 32'h1, big_end);
		wr(2'h1, {2'h0, SSNC_MUX_PASSTHRU});
		rd(2'h0, d);
		chk("soft reset gcr", 32'h03, d);
		chk("soft reset ped", 32'h0, pedestal);
	endtask

	task t_polarity;
		wr(2'h1, 8'h00);
		for (int p = 0; p < 4; p++)
		begin
			wr(2'h0, 8'h20 | 8'(p));
			video(1'b1, 1'b1, 1'b1, 1'b0, 32'h0);
			chk("line active", 32'(p & 1), line_sync_out);
			chk("frame active", 32'(p >> 1), frame_sync_out);
			chk("green in sync", 32'h0, green);
			chk("retrace active", 32'h0, retr_out_n);
			video(1'b0, 1'b0, 1'b0, 1'b0, 32'h0);
			chk("line idle", 32'(~p & 1), line_sync_out);
			chk("green idle", 32'h1, green);
			chk("retrace idle", 32'h1, retr_out_n);
		end
	endtask

	task t_pass;
		wr(2'h1, {2'h0, SSNC_MUX_PASSTHRU});
		video(1'b1, 1'b1, 1'b1, 1'b0, 32'h0);
		chk("pass line", 32'h0, line_sync_out);
		chk("pass frame", 32'h0, frame_sync_out);
		video(1'b0, 1'b0, 1'b0, 1'b0, 32'h0);
		chk("pass idle", 32'h1, line_sync_out);
		rd(2'h2, d);
		chk("status", 32'h17, d);
	endtask

	task t_split(input logic [7:0] g, input int exp);
		logic [31:0] n;
		wr(2'h1, 8'h00);
		wr(2'h0, g);
		video(1'b1, 1'b0, 1'b0, 1'b0, 32'h0);
		count_high(n);
		chk("flag low", 32'h0, n);
		@(posedge clk);
		flag_req <= 1'b1;
		count_high(n);
		chk("extra pulse", exp, n);
		video(1'b1, 1'b0, 1'b0, 1'b0, 32'h0);
		video(1'b0, 1'b0, 1'b0, 1'b0, 32'h0);
	endtask

	task t_pixel;
		logic [31:0] pix;
		logic [7:0]  g [5];
		logic [7:0]  m [5];
		logic        fl [5];
		logic [31:0] e [5];
		pix = 32'ha5c37e19;
		g  = '{8'h00, 8'h08, 8'h08, 8'h08, 8'h40};
		m  = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
		fl = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
		e  = '{pix, 32'h0a0c0701, 32'h05030e09, 32'h0a0c0701, 32'h0};
		e[4] = {<<{pix}};
		for (int i = 0; i < 5; i++)
		begin
			wr(2'h1, m[i]);
			wr(2'h0, g[i]);
			video(1'b1, 1'b0, 1'b0, fl[i], pix);
			video(1'b0, 1'b0, 1'b0, fl[i], pix);
			chk("pixel out", e[i], pixel_out);
		end
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		t_reset;
		t_control;
		t_polarity;
		t_pass;
		t_split(8'h04, SSNC_PULSE_HIGH_CYC);
		t_split(8'h00, 0);
		t_pixel;
		stop_test;
	end

	// Cuts a hang short well inside the cycle budget
	initial
	begin
		repeat (90000) @(posedge clk);
		$display("ERROR timeout expected finish seen hang");
		err_count++;
		stop_test;
	end
endmodule // tb_top
